// ==== core/tc_timer.sv ====
// 8-bit timer/counter with double-buffered reload, buzzer and PWM, AXI4-Lite slave.
// Assumes event_in is asynchronous; GPIO pin values come from the PIN register.
// Function
// R1 - Overflow sets flag until software clears
// R2 - Counter reloads automatically after each overflow
// R3 - Boundary 256, or 64/32/16 in PWM
// R4 - Software keeps values within resolution range
// R5 - Reload write buffered until next overflow
// R6 - Software presets counter equal to reload
// R7 - External source counts falling pin edges
// R8 - Step from FF to 00 is overflow
// R9 - Event counting disables pin wake-up
// R10 - Event counting disables pin interrupt, flag zero
// R11 - Buzzer output toggles on every overflow
// R12 - Buzzer enable muxes shared pin from GPIO
// R13 - Flag and interrupt still work in buzzer/PWM
// R14 - Software keeps PWM off while buzzing
// R15 - PWM cycle starts high, then low
// R16 - PWM counter starts from zero
// R17 - PWM low at match, high at overflow
// R18 - New duty applies from next cycle
// R19 - PWM enable muxes shared pin from GPIO
// R20 - Reduced resolution wraps low bits only
// R21 - Internal source through prescaler 256..2
// R22 - Counter runs only while enabled
// R23 - Auto-reload by bit, forced in PWM
//
// Implementation choice: register access over AXI4-Lite.
`default_nettype none
module tc_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`TC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output tc_pkg::resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output tc_pkg::resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic event_in,
  input wire logic event_pin_edge,
  output logic out_pin,
  output logic out_pin_oe,
  output logic overflow_irq,
  output logic event_pin_irq,
  output logic event_pin_wake
);
  import tc_pkg::*;
  // ==========================================
  // Registers
  byte_t counter_value;
  byte_t reload_stage;
  byte_t reload_value;
  logic timer_enable;
  rate_t prescaler_select;
  logic clock_source_select;
  logic auto_reload_enable;
  logic buzzer_output_enable;
  logic pwm_output_enable;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic event_pin_irq_flag;
  logic event_pin_irq_enable;
  logic event_wake_enable;
  logic gpio_out;
  logic gpio_oe;
  logic buzzer;
  logic pwm;
  logic enable_d;
  // ==========================================
  // AXI write channel
  logic aw_held;
  logic w_held;
  logic [`TC_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic lane0;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  // Write commits once both address and data are held
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign lane0 = w_strb[0];
  wire wr_mapped = aw_addr == `TC_ADDR_RELOAD || aw_addr == `TC_ADDR_COUNTER ||
    aw_addr == `TC_ADDR_MODE || aw_addr == `TC_ADDR_IRQ || aw_addr == `TC_ADDR_PIN;
  wire wr_reload = do_write && lane0 && aw_addr == `TC_ADDR_RELOAD;
  wire wr_counter = do_write && lane0 && aw_addr == `TC_ADDR_COUNTER;
  wire wr_mode = do_write && lane0 && aw_addr == `TC_ADDR_MODE;
  wire wr_irq = do_write && lane0 && aw_addr == `TC_ADDR_IRQ;
  wire wr_pin = do_write && lane0 && aw_addr == `TC_ADDR_PIN;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ==========================================
  // AXI read channel
  logic [31:0] rd_word;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_mapped = s_axi_araddr == `TC_ADDR_RELOAD || s_axi_araddr == `TC_ADDR_COUNTER ||
    s_axi_araddr == `TC_ADDR_MODE || s_axi_araddr == `TC_ADDR_IRQ || s_axi_araddr == `TC_ADDR_PIN;
  wire [7:0] mode_byte = {timer_enable, prescaler_select, clock_source_select,
    auto_reload_enable, buzzer_output_enable, pwm_output_enable};
  wire [7:0] irq_byte = {6'h00, overflow_irq_enable, overflow_flag};
  wire [7:0] pin_byte = {3'h0, event_wake_enable, event_pin_irq_enable, event_pin_irq_flag, gpio_oe, gpio_out};
  // Reload register is write-only: reads return zero
  assign rd_word = (s_axi_araddr == `TC_ADDR_COUNTER) ? {24'h000000, counter_value} :
    (s_axi_araddr == `TC_ADDR_MODE) ? {24'h000000, mode_byte} :
    (s_axi_araddr == `TC_ADDR_IRQ) ? {24'h000000, irq_byte} :
    (s_axi_araddr == `TC_ADDR_PIN) ? {24'h000000, pin_byte} : 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_mapped ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ==========================================
  // Clock sources
  logic presc_tick;
  logic ext_fall;
  tc_prescaler #(.WIDTH(`TC_PRESC_W)) u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(timer_enable && !clock_source_select),
    .rate(prescaler_select),
    .tick(presc_tick)
  );
  tc_edge_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(event_in),
    .fall_pulse(ext_fall)
  );
  // ==========================================
  // Counting core
  logic step;
  byte_t span_mask;
  byte_t next_counter;
  logic wrap;
  logic reload_on;
  logic pwm_mode;
  assign pwm_mode = pwm_output_enable && !clock_source_select;
  // Source select: prescaled clock or falling pin edges; only while enabled
  assign step = timer_enable && (clock_source_select ? ext_fall : presc_tick); // see R7 see R21 see R22
  // Resolution picks how many low bits count
  assign span_mask = !pwm_mode ? `TC_BYTE_MAX : // see R3
    ({auto_reload_enable, buzzer_output_enable} == 2'b00) ? 8'hFF :
    ({auto_reload_enable, buzzer_output_enable} == 2'b01) ? 8'h3F :
    ({auto_reload_enable, buzzer_output_enable} == 2'b10) ? 8'h1F : 8'h0F;
  // Overflow when the counted field is full; FF to 00 at full width
  assign wrap = step && ((counter_value & span_mask) == span_mask); // see R8 see R20
  assign reload_on = pwm_mode || auto_reload_enable; // see R23
  // PWM counts from zero each period; other modes reload the preset when auto-reload is set, else restart at zero
  // Value moving into the active buffer at this overflow also starts the next period
  wire [7:0] reload_next = wr_reload ? w_data[7:0] : reload_stage;
  assign next_counter = wrap ? (pwm_mode ? `TC_BYTE_ZERO : (reload_on ? reload_next : `TC_BYTE_ZERO)) // see R2 see R16
    : (counter_value + 8'h01) & span_mask;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value <= `TC_RESET_BYTE;
      enable_d <= 1'b0;
    end else begin
      enable_d <= timer_enable;
      if (wr_counter) begin
        counter_value <= w_data[7:0];
      end else if (pwm_mode && timer_enable && !enable_d) begin
        counter_value <= `TC_BYTE_ZERO; // see R16
      end else if (step) begin
        counter_value <= next_counter;
      end
    end
  end
  // Double buffer: write lands in stage, moves at overflow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_stage <= `TC_RESET_BYTE;
      reload_value <= `TC_RESET_BYTE;
    end else begin
      if (wr_reload) begin
        reload_stage <= w_data[7:0]; // see R5
      end
      // Disabled timer lets the preset take effect for the first period
      if (wrap || !timer_enable) begin
        reload_value <= reload_next; // see R5 see R18
      end
    end
  end
  // ==========================================
  // Mode and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_enable <= 1'b0;
      prescaler_select <= 3'h0;
      clock_source_select <= 1'b0;
      auto_reload_enable <= 1'b0;
      buzzer_output_enable <= 1'b0;
      pwm_output_enable <= 1'b0;
      overflow_irq_enable <= 1'b0;
      event_pin_irq_enable <= 1'b0;
      event_wake_enable <= 1'b0;
      gpio_out <= 1'b0;
      gpio_oe <= 1'b0;
    end else begin
      if (wr_mode) begin
        timer_enable <= w_data[`TC_MODE_EN_BIT];
        prescaler_select <= w_data[`TC_MODE_RATE_HI:`TC_MODE_RATE_LO];
        clock_source_select <= w_data[`TC_MODE_CKS_BIT];
        auto_reload_enable <= w_data[`TC_MODE_ALOAD_BIT];
        buzzer_output_enable <= w_data[`TC_MODE_BUZ_BIT];
        pwm_output_enable <= w_data[`TC_MODE_PWM_BIT];
      end
      if (wr_irq) begin
        overflow_irq_enable <= w_data[`TC_IRQ_EN_BIT];
      end
      if (wr_pin) begin
        gpio_out <= w_data[`TC_PIN_GPIO_OUT_BIT];
        gpio_oe <= w_data[`TC_PIN_GPIO_OE_BIT];
        event_pin_irq_enable <= w_data[`TC_PIN_EVIEN_BIT];
        event_wake_enable <= w_data[`TC_PIN_WAKE_BIT];
      end
    end
  end
  // ==========================================
  // Flags: hardware set wins over software clear
  wire ovf_clear = wr_irq && !w_data[`TC_IRQ_FLAG_BIT];
  wire ev_clear = wr_pin && !w_data[`TC_PIN_EVFLAG_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
      event_pin_irq_flag <= 1'b0;
    end else begin
      if (wrap) begin
        overflow_flag <= 1'b1; // see R1 see R13
      end else if (ovf_clear) begin
        overflow_flag <= 1'b0;
      end
      if (clock_source_select) begin
        event_pin_irq_flag <= 1'b0; // see R10
      end else if (event_pin_edge) begin
        event_pin_irq_flag <= 1'b1;
      end else if (ev_clear) begin
        event_pin_irq_flag <= 1'b0;
      end
    end
  end
  // ==========================================
  // Buzzer and PWM waveforms
  // Low on the same edge the counter reaches the duty, so high lasts duty counts
  wire pwm_match = step && !wrap && next_counter == reload_value;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buzzer <= 1'b0;
      pwm <= 1'b1;
    end else begin
      if (wrap) begin
        buzzer <= ~buzzer; // see R11
      end
      if (!timer_enable || !pwm_mode) begin
        pwm <= 1'b1; // see R15
      end else if (wrap) begin
        pwm <= 1'b1; // see R17
      end else if (pwm_match) begin
        pwm <= 1'b0; // see R17
      end
    end
  end
  // ==========================================
  // Outputs, all registered; GPIO setting kept and restored on disable
  wire pin_pwm = pwm_output_enable && timer_enable; // see R19
  wire pin_buz = buzzer_output_enable && !pwm_output_enable; // see R12
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_pin <= 1'b0;
      out_pin_oe <= 1'b0;
      overflow_irq <= 1'b0;
      event_pin_irq <= 1'b0;
      event_pin_wake <= 1'b0;
    end else begin
      out_pin <= pin_pwm ? pwm : (pin_buz ? buzzer : gpio_out);
      out_pin_oe <= pin_pwm || pin_buz || gpio_oe;
      overflow_irq <= overflow_flag && overflow_irq_enable; // see R13
      event_pin_irq <= event_pin_irq_flag && event_pin_irq_enable && !clock_source_select; // see R10
      event_pin_wake <= event_pin_edge && event_wake_enable && !clock_source_select; // see R9
    end
  end
  // ==========================================
  // Checks
  ovf_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn) wrap |=> overflow_flag) // see R1
    else $error("overflow did not set flag");
  auto_reload_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R2
    wrap && !pwm_mode && auto_reload_enable && !wr_counter |=> counter_value == reload_value)
    else $error("counter not reloaded");
  pwm_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R20
    wrap && pwm_mode && !wr_counter |=> counter_value == 8'h00)
    else $error("pwm counter not zero after overflow");
  ev_flag_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R10
    $past(clock_source_select) && clock_source_select |-> !event_pin_irq_flag && !event_pin_irq)
    else $error("event pin flag raised in counter mode");
  wake_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R9
    $past(clock_source_select) |-> !event_pin_wake)
    else $error("wake raised in counter mode");
  buzz_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn) wrap |=> buzzer != $past(buzzer)) // see R11
    else $error("buzzer did not toggle");
  hold_stop_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R22
    !timer_enable && !wr_counter |=> $stable(counter_value))
    else $error("counter moved while disabled");
  stage_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R5
    timer_enable && !wrap |=> $stable(reload_value))
    else $error("active reload changed without overflow");
  pwm_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R17
    timer_enable && pwm_mode && pwm_match |=> !pwm)
    else $error("pwm not low at match");
endmodule // tc_timer
`default_nettype wire

// ==== core/tc_defs.svh ====
// Register offsets, field positions and reset values for the 8-bit timer/counter.
// Assumes inclusion by the package and the testbench only.
`ifndef TC_DEFS_SVH
`define TC_DEFS_SVH
// ==========================================
// Register indices; one aligned word each, so byte address is four times the index
`define TC_IDX_RELOAD 8'hCD
`define TC_IDX_COUNTER 8'hDB
`define TC_IDX_MODE 8'hDA
`define TC_IDX_IRQ 8'hE0
`define TC_IDX_PIN 8'hE4
`define TC_ADDR_RELOAD {`TC_IDX_RELOAD, 2'b00}
`define TC_ADDR_COUNTER {`TC_IDX_COUNTER, 2'b00}
`define TC_ADDR_MODE {`TC_IDX_MODE, 2'b00}
`define TC_ADDR_IRQ {`TC_IDX_IRQ, 2'b00}
`define TC_ADDR_PIN {`TC_IDX_PIN, 2'b00}
// ==========================================
// Mode register fields
`define TC_MODE_PWM_BIT 0
`define TC_MODE_BUZ_BIT 1
`define TC_MODE_ALOAD_BIT 2
`define TC_MODE_CKS_BIT 3
`define TC_MODE_RATE_LO 4
`define TC_MODE_RATE_HI 6
`define TC_MODE_EN_BIT 7
// ==========================================
// Interrupt/pin register fields
`define TC_IRQ_FLAG_BIT 0
`define TC_IRQ_EN_BIT 1
`define TC_PIN_GPIO_OUT_BIT 0
`define TC_PIN_GPIO_OE_BIT 1
`define TC_PIN_EVFLAG_BIT 2
`define TC_PIN_EVIEN_BIT 3
`define TC_PIN_WAKE_BIT 4
// ==========================================
// Reset values and widths
`define TC_RESET_BYTE 8'h00
`define TC_BYTE_MAX 8'hFF
`define TC_BYTE_ZERO 8'h00
`define TC_PRESC_W 8
`define TC_RESP_OKAY 2'b00
`define TC_RESP_SLVERR 2'b10
`define TC_ADDR_W 10
`endif

// ==== core/tc_pkg.sv ====
// Types shared by the timer/counter core.
// Assumes tc_defs.svh sits on the include path.
`default_nettype none
package tc_pkg;
  `include "tc_defs.svh"
  typedef logic [7:0] byte_t;
  typedef logic [2:0] rate_t;
  typedef logic [1:0] resp_t;
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_RESP = 3'b010,
    WR_HOLD = 3'b100
  } wr_state_e;
endpackage
`default_nettype wire

// ==== core/tc_edge_sync.sv ====
// Two-stage synchroniser with falling-edge pulse for the event pin.
// Assumes the input may change at any time relative to aclk.
`default_nettype none
module tc_edge_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic fall_pulse
);
  logic meta;
  logic sync;
  logic sync_d;
  // Only sync and sync_d feed the edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b1;
      sync <= 1'b1;
      sync_d <= 1'b1;
    end else begin
      meta <= async_in;
      sync <= meta;
      sync_d <= sync;
    end
  end
  assign fall_pulse = sync_d & ~sync;
endmodule // tc_edge_sync
`default_nettype wire

// ==== core/tc_prescaler.sv ====
// Free divider giving one tick per 2..256 clocks by rate code.
// Assumes aclk is the instruction clock.
`default_nettype none
module tc_prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire tc_pkg::rate_t rate,
  output logic tick
);
  import tc_pkg::*;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic [WIDTH-1:0] mask;
  assign next_count = run ? count + 1'b1 : '0;
  // Code 000 divides by 256, 111 by 2
  assign mask = {WIDTH{1'b1}} >> rate;
  assign tick = run && ((count & mask) == mask);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule // tc_prescaler
`default_nettype wire

// ==== dv/tc_pin_partner.sv ====
// Far-side model of the event input pin and the shared output pin.
// Assumes a pull-up on the event pin and an output looked at on aclk.
`default_nettype none
module tc_pin_partner (
  input wire logic aclk,
  output logic event_in,
  input wire logic out_pin,
  input wire logic out_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  int run_len = 0;
  int last_high = 0;
  int last_low = 0;
  logic prev_pin = 1'b0;
  initial event_in = 1'b1;
  // ==========================================
  // Event pulses, phase unrelated to aclk
  task automatic pulse(input int n, input int width_ns);
    repeat (n) begin
      #(width_ns) event_in = 1'b0;
      #(width_ns) event_in = 1'b1;
    end
  endtask
  // ==========================================
  // Run lengths of the driven pin, in clocks
  always @(posedge aclk) begin
    if (out_pin_oe === 1'b1 && out_pin === prev_pin) begin
      run_len <= run_len + 1;
    end else begin
      if (prev_pin === 1'b1) last_high <= run_len;
      if (prev_pin === 1'b0) last_low <= run_len;
      run_len <= 1;
    end
    // Released pin is not a level
    prev_pin <= out_pin_oe ? out_pin : 1'bx;
  end
endmodule // tc_pin_partner
`default_nettype wire

// ==== dv/test_timer_counter_pwm_buzzer.sv ====
// Self-checking bench: AXI4-Lite tasks, read scoreboard, pin partner.
// Assumes tc_defs.svh on the include path and the partner compiled first.
`include "tc_defs.svh"
`default_nettype none
module test_timer_counter_pwm_buzzer;
  timeunit 1ns;
  timeprecision 1ns;
  import tc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, event_pin_edge = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic event_in, out_pin, out_pin_oe, overflow_irq, event_pin_irq, event_pin_wake;
  resp_t s_axi_bresp, s_axi_rresp;
  logic [43:0] exp_q[$];
  logic [43:0] e;
  logic [9:0] addr_tab [6] = '{`TC_ADDR_MODE, `TC_ADDR_COUNTER, `TC_ADDR_RELOAD, `TC_ADDR_IRQ, `TC_ADDR_PIN, 10'h010};
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h23AA;

  tc_timer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .event_in, .event_pin_edge, .out_pin, .out_pin_oe, .overflow_irq,
    .event_pin_irq, .event_pin_wake);
  tc_pin_partner u_partner (.aclk, .event_in, .out_pin, .out_pin_oe);

  always #50 aclk = ~aclk;

  // ==========================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string what, input logic [33:0] ex, input logic [33:0] got);
    n_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, ex, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic timeout();
    check("wait", 34'h0, 34'h1);
    end_of_test();
  endtask

  // ==========================================
  // AXI4-Lite master
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input resp_t er = `TC_RESP_OKAY);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 40) timeout();
    check("bresp", 34'(er), 34'(s_axi_bresp));
  endtask

  // Expected read noted before the request
  task automatic rd(input logic [9:0] a, input logic [7:0] d, input resp_t er = `TC_RESP_OKAY);
    int i;
    exp_q.push_back({a, er, 24'h0, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 40) timeout();
  endtask

  always @(posedge aclk) begin
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      if (exp_q.size() == 0) begin
        check("unexpected read", 34'h0, 34'h1);
      end else begin
        e = exp_q.pop_front();
        check($sformatf("read %h", e[43:34]), e[33:0], {s_axi_rresp, s_axi_rdata});
      end
    end
  end

  // ==========================================
  // Pin-side waits
  task automatic wait_ovf(output time t);
    int i;
    for (i = 0; i < 20000; i++) begin
      @(posedge aclk);
      if (overflow_irq === 1'b1) break;
    end
    if (i == 20000) timeout();
    t = $time;
  endtask

  task automatic edge_req(output logic w, output logic q);
    w = 1'b0;
    q = 1'b0;
    @(posedge aclk);
    event_pin_edge <= 1'b1;
    @(posedge aclk);
    event_pin_edge <= 1'b0;
    repeat (3) begin
      @(posedge aclk);
      w = w | event_pin_wake;
      q = q | event_pin_irq;
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    time t0, t1;
    logic [7:0] p, d;
    logic w, q;
    int n;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(addr_tab[i], 8'h00, (i == 5) ? `TC_RESP_SLVERR : `TC_RESP_OKAY);
    wr(10'h010, 8'h5A, `TC_RESP_SLVERR);
    // Period per rate code, reload changed while running
    for (int r = 0; r < 8; r++) begin
      p = 8'hF0 | 8'(xs() & 32'h7);
      wr(`TC_ADDR_MODE, 8'h00);
      wr(`TC_ADDR_COUNTER, 8'hF0);
      wr(`TC_ADDR_RELOAD, 8'hF0);
      wr(`TC_ADDR_IRQ, 8'h02);
      wr(`TC_ADDR_MODE, {1'b1, 3'(r), 4'b0100});
      wr(`TC_ADDR_RELOAD, p);
      wait_ovf(t0);
      wr(`TC_ADDR_IRQ, 8'h02);
      wait_ovf(t1);
      check("ovf period", 34'((256 - p) * (256 >> r)), 34'((t1 - t0) / 100));
    end
    wr(`TC_ADDR_MODE, 8'h00);
    wr(`TC_ADDR_COUNTER, 8'h55);
    repeat (600) @(posedge aclk);
    rd(`TC_ADDR_COUNTER, 8'h55);
    // Event counting across the wrap
    wr(`TC_ADDR_COUNTER, 8'hFD);
    wr(`TC_ADDR_RELOAD, 8'hFD);
    wr(`TC_ADDR_IRQ, 8'h02);
    wr(`TC_ADDR_PIN, 8'h18);
    wr(`TC_ADDR_MODE, 8'h8C);
    // Widths of 37 mod 100 ns keep every pin change off a clock edge
    u_partner.pulse(3, 337 + 100 * int'(xs() % 3));
    repeat (10) @(posedge aclk);
    rd(`TC_ADDR_IRQ, 8'h03);
    rd(`TC_ADDR_COUNTER, 8'hFD);
    edge_req(w, q);
    check("wake in counter mode", 34'(w), 34'h0);
    check("pin irq in counter mode", 34'(q), 34'h0);
    rd(`TC_ADDR_PIN, 8'h18);
    wr(`TC_ADDR_MODE, 8'h00);
    edge_req(w, q);
    check("wake in timer mode", 34'(w), 34'h1);
    check("pin irq in timer mode", 34'(q), 34'h1);
    rd(`TC_ADDR_PIN, 8'h1C);
    // Buzzer on a GPIO-driven pin
    wr(`TC_ADDR_PIN, 8'h03);
    wr(`TC_ADDR_COUNTER, 8'hF0);
    wr(`TC_ADDR_RELOAD, 8'hF0);
    wr(`TC_ADDR_IRQ, 8'h02);
    repeat (4) @(posedge aclk);
    check("gpio pin", 34'({out_pin_oe, out_pin}), 34'h3);
    wr(`TC_ADDR_MODE, 8'hF6);
    repeat (200) @(posedge aclk);
    check("buzzer high", 34'h20, 34'(u_partner.last_high));
    check("buzzer low", 34'h20, 34'(u_partner.last_low));
    rd(`TC_ADDR_IRQ, 8'h03);
    wr(`TC_ADDR_PIN, 8'h02);
    wr(`TC_ADDR_MODE, 8'hF4);
    wr(`TC_ADDR_IRQ, 8'h02);
    check("gpio after buzzer", 34'({out_pin_oe, out_pin}), 34'h2);
    wait_ovf(t0);
    // PWM at every resolution, duty changed while running
    for (int m = 0; m < 4; m++) begin
      n = (m == 0) ? 256 : (64 >> (m - 1));
      for (int k = 0; k < 2; k++) begin
        d = 8'(1 + xs() % (n - 1));
        if (k == 0) begin
          wr(`TC_ADDR_MODE, 8'h00);
          wr(`TC_ADDR_PIN, 8'h00);
          wr(`TC_ADDR_COUNTER, 8'h00);
        end
        wr(`TC_ADDR_RELOAD, d);
        if (k == 0) wr(`TC_ADDR_MODE, {4'hF, 1'b0, 2'(m), 1'b1});
        repeat (n * 8) @(posedge aclk);
        check("pwm oe", 34'(out_pin_oe), 34'h1);
        check("pwm high", 34'(d * 2), 34'(u_partner.last_high));
        check("pwm low", 34'((n - d) * 2), 34'(u_partner.last_low));
      end
    end
    wr(`TC_ADDR_MODE, 8'h00);
    repeat (4) @(posedge aclk);
    check("gpio after pwm", 34'({out_pin_oe, out_pin}), 34'h0);
    end_of_test();
  end
endmodule // test_timer_counter_pwm_buzzer
`default_nettype wire
